// ---- src/csmh_pkg.sv ----
// Constants, modes and state types for the configuration start and handshake block
package csmh_pkg;
	localparam int CLK_PERIOD_NS = 40;
	localparam int CLR_CYCLE_NS = 1000;
	localparam int CLR_CYCLES = (CLR_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CLR_W = 6;
	localparam logic [CLR_W-1:0] CLR_LAST = CLR_W'(CLR_CYCLES - 1);
	localparam logic [CLR_W-1:0] CLR_ZERO = 6'h00;
	localparam int ADDR_W = 18;
	localparam int DATA_W = 8;
	localparam int MODE_W = 3;
	localparam int SYNC_W = 17;
	localparam logic [ADDR_W-1:0] ADDR_ZERO = 18'h00000;
	localparam logic [ADDR_W-1:0] ADDR_ONE = 18'h00001;
	localparam logic [6:0] LOW_BITS_HIGH = 7'h7F;
	localparam logic [DATA_W-1:0] BYTE_ZERO = 8'h00;
	// Mode pin encodings
	localparam logic [MODE_W-1:0] MODE_SLAVE_SERIAL = 3'h7;
	localparam logic [MODE_W-1:0] MODE_MASTER_SERIAL = 3'h0;
	localparam logic [MODE_W-1:0] MODE_MASTER_PARALLEL = 3'h6;
	localparam logic [MODE_W-1:0] MODE_PERIPH_SYNC = 3'h3;
	localparam logic [MODE_W-1:0] MODE_PERIPH_ASYNC = 3'h5;
	// Synchroniser bit positions
	localparam int SY_PROG = 0;
	localparam int SY_INIT = 1;
	localparam int SY_MODE0 = 2;
	localparam int SY_MODE1 = 3;
	localparam int SY_MODE2 = 4;
	localparam int SY_CSLOW = 5;
	localparam int SY_CSHIGH = 6;
	localparam int SY_WSTRB = 7;
	localparam int SY_RSTRB = 8;
	localparam int SY_DATA = 9;
	localparam logic [SYNC_W-1:0] SYNC_RESET = 17'h001FD;

	typedef enum logic [2:0] {
		ST_CLEAR,
		ST_FINISH,
		ST_EXTRA,
		ST_WAIT,
		ST_LOAD,
		ST_USER
	} csmh_state_t;

	function automatic logic csmh_is_periph(input logic [MODE_W-1:0] m);
		return (m == MODE_PERIPH_ASYNC) || (m == MODE_PERIPH_SYNC);
	endfunction : csmh_is_periph
endpackage : csmh_pkg

// ---- src/csmh_sync.sv ----
// Two-stage synchroniser for pin inputs
`timescale 1ns/1ps
module csmh_sync (
	input wire logic clock, // System clock
	input wire logic arst_n, // Async reset, active low
	input wire logic [csmh_pkg::SYNC_W-1:0] pinIn, // Raw pin levels
	output logic [csmh_pkg::SYNC_W-1:0] syncOut // Synchronised levels
);
	import csmh_pkg::*;

	typedef struct packed {
		logic [SYNC_W-1:0] stage1;
		logic [SYNC_W-1:0] stage2;
	} csmh_sync_t;

	csmh_sync_t s_r, s_nxt;

	always_comb begin
		s_nxt = s_r;
		s_nxt.stage1 = pinIn;
		s_nxt.stage2 = s_r.stage1;
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			s_r <= {SYNC_RESET, SYNC_RESET};
		end else begin
			s_r <= s_nxt;
		end
	end

	assign syncOut = s_r.stage2;
endmodule : csmh_sync

// ---- src/csmh_config_ctrl.sv ----
// Configuration start, mode sampling and load handshake control
`timescale 1ns/1ps
module csmh_config_ctrl (
	input wire logic clock, // 25 MHz system clock
	input wire logic arst_n, // Async reset, active low
	input wire logic programReqPin_n, // Clear request pin, active low
	input wire logic initPinIn, // Level seen on init pin
	output logic initOe, // Init pin pulled low when high
	output logic eraseMem, // Configuration memory erase
	input wire logic cfg_mode_sel_0, // Mode pin 0 (weak pull-up outside)
	input wire logic cfg_mode_sel_1, // Mode pin 1 (weak pull-up outside)
	input wire logic cfg_mode_sel_2, // Mode pin 2 (weak pull-up outside)
	output logic [csmh_pkg::MODE_W-1:0] modeSampled, // Captured mode
	output logic modeSel0User, // Mode pin 0 as user input
	output logic modeSel2User, // Mode pin 2 as user input
	input wire logic userSel1Out, // User value for mode pin 1
	input wire logic userSel1Oe, // User enable for mode pin 1
	output logic modeSel1Out, // Mode pin 1 output
	output logic modeSel1Oe, // Mode pin 1 output enable
	input wire logic chip_select_low_active, // Chip select, active low pin
	input wire logic chip_select_high_active, // Chip select, active high pin
	input wire logic write_strobe_n, // Write strobe pin
	input wire logic read_strobe_n, // Read strobe pin
	input wire logic [csmh_pkg::DATA_W-1:0] dataPinIn, // Data pins in
	output logic top_data_bit, // Status on data bit 7
	output logic [6:0] dataLowOut, // Data bits 6..0 out
	output logic dataOe, // Data pins output enable
	output logic [csmh_pkg::DATA_W-1:0] cfgByte, // Buffered byte to loader
	output logic cfgByteValid, // Byte buffer full
	input wire logic loaderTake, // Loader consumes buffered byte
	input wire logic cfgDone, // Loader signals configuration done
	output logic readyBusyOut, // Ready/busy pin out
	output logic readyBusyOe, // Ready/busy pin drive enable
	output logic readyBusyPullup, // Ready/busy weak pull-up enable
	input wire logic userRdyOut, // User value for ready/busy pin
	input wire logic userRdyOe, // User enable for ready/busy pin
	input wire logic addrStepReq, // Loader asks for next address
	output logic [csmh_pkg::ADDR_W-1:0] prom_address_out, // PROM address
	output logic promAddrOe, // PROM address drive enable
	output logic addrAdvClk, // Address advance clock
	output logic addrAdvClkOe, // Address advance clock enable
	input wire logic userAclkOut, // User value for address clock pin
	input wire logic userAclkOe, // User enable for address clock pin
	input wire logic scanEnable, // Boundary scan enabled
	input wire logic scanTdo, // Scan chain data out
	input wire logic userTdoOut, // User value for test output
	input wire logic userTdoOe, // User enable for test output
	output logic testDataOut, // Test data output pin
	output logic testDataOe // Test data output enable
);
	import csmh_pkg::*;

	typedef struct packed {
		csmh_state_t st;
		logic [CLR_W-1:0] clrCnt;
		logic [MODE_W-1:0] mode;
		logic wsPrev;
		logic bufFull;
		logic [DATA_W-1:0] byteBuf;
		logic initOe;
		logic erase;
		logic sel0User;
		logic sel2User;
		logic sel1Out;
		logic sel1Oe;
		logic topBit;
		logic [6:0] dLow;
		logic dOe;
		logic rdyOut;
		logic rdyOe;
		logic rdyPull;
		logic [ADDR_W-1:0] addr;
		logic addrOe;
		logic aclk;
		logic aclkOe;
		logic tdo;
		logic tdoOe;
	} csmh_ctrl_t;

	csmh_ctrl_t s_r, s_nxt;
	logic [SYNC_W-1:0] pinSync;
	logic progN, selected, wsLow, rsLow, clrWrap, periph, isAsync, isMpar;

	csmh_sync u_sync (
		.clock(clock),
		.arst_n(arst_n),
		.pinIn({dataPinIn, read_strobe_n, write_strobe_n, chip_select_high_active,
			chip_select_low_active, cfg_mode_sel_2, cfg_mode_sel_1, cfg_mode_sel_0,
			initPinIn, programReqPin_n}),
		.syncOut(pinSync)
	);

	assign progN = pinSync[SY_PROG];
	assign selected = !pinSync[SY_CSLOW] && pinSync[SY_CSHIGH];
	assign wsLow = !pinSync[SY_WSTRB];
	assign rsLow = !pinSync[SY_RSTRB];
	assign clrWrap = (s_r.clrCnt == CLR_LAST);
	assign periph = csmh_is_periph(s_r.mode);
	assign isAsync = (s_r.mode == MODE_PERIPH_ASYNC);
	assign isMpar = (s_r.mode == MODE_MASTER_PARALLEL);

	always_comb begin
		s_nxt = s_r;
		s_nxt.wsPrev = wsLow;
		s_nxt.clrCnt = clrWrap ? CLR_ZERO : s_r.clrCnt + 1'b1;
		s_nxt.aclk = 1'b0;
		case (s_r.st)
			ST_CLEAR: begin
				if (progN) begin
					s_nxt.st = ST_FINISH;
				end
			end
			ST_FINISH: begin
				if (clrWrap) begin
					s_nxt.st = ST_EXTRA;
				end
			end
			ST_EXTRA: begin
				if (clrWrap) begin
					s_nxt.st = ST_WAIT;
				end
			end
			ST_WAIT: begin
				if (pinSync[SY_INIT]) begin
					// Open pins read high via pull-ups, giving slave serial
					s_nxt.mode = pinSync[SY_MODE2:SY_MODE0];
					s_nxt.addr = ADDR_ZERO;
					s_nxt.st = ST_LOAD;
				end
			end
			ST_LOAD: begin
				if (loaderTake) begin
					s_nxt.bufFull = 1'b0;
				end
				// Write wins over read; new byte only when empty
				if (isAsync && selected && wsLow && !s_r.wsPrev && !s_r.bufFull) begin
					s_nxt.byteBuf = pinSync[SY_DATA +: DATA_W];
					s_nxt.bufFull = 1'b1;
				end
				// Clock rises, then next cycle the address moves and the clock falls together
				if (isMpar && s_r.aclk) begin
					s_nxt.addr = s_r.addr + ADDR_ONE;
				end
				if (isMpar && addrStepReq && !s_r.aclk) begin
					s_nxt.aclk = 1'b1;
				end
				if (cfgDone) begin
					s_nxt.st = ST_USER;
				end
			end
			ST_USER: begin
				s_nxt.bufFull = 1'b0;
			end
			default: begin
				s_nxt.st = ST_CLEAR;
			end
		endcase
		if (!progN) begin
			s_nxt.st = ST_CLEAR;
			s_nxt.bufFull = 1'b0;
		end
		if (s_nxt.st == ST_CLEAR || (s_r.st == ST_CLEAR && s_nxt.st == ST_FINISH)) begin
			s_nxt.clrCnt = (s_r.st == ST_CLEAR) ? s_nxt.clrCnt : CLR_ZERO;
		end
		// Output stage, all registered
		s_nxt.erase = (s_nxt.st == ST_CLEAR) || (s_nxt.st == ST_FINISH)
			|| (s_nxt.st == ST_EXTRA);
		s_nxt.initOe = s_nxt.erase;
		s_nxt.rdyPull = (s_nxt.st != ST_LOAD) && (s_nxt.st != ST_USER);
		s_nxt.rdyOe = 1'b0;
		s_nxt.rdyOut = 1'b1;
		s_nxt.dOe = 1'b0;
		s_nxt.topBit = 1'b1;
		s_nxt.dLow = LOW_BITS_HIGH;
		s_nxt.addrOe = 1'b0;
		s_nxt.aclkOe = 1'b0;
		s_nxt.sel1Out = 1'b0;
		s_nxt.sel1Oe = 1'b0;
		s_nxt.sel0User = 1'b0;
		s_nxt.sel2User = 1'b0;
		s_nxt.tdo = 1'b0;
		s_nxt.tdoOe = 1'b0;
		if (s_nxt.st == ST_LOAD && csmh_is_periph(s_nxt.mode)) begin
			s_nxt.rdyOe = 1'b1;
			s_nxt.rdyOut = !s_nxt.bufFull;
			if (s_nxt.mode == MODE_PERIPH_ASYNC && selected && rsLow && !wsLow) begin
				s_nxt.dOe = 1'b1;
				s_nxt.topBit = !s_nxt.bufFull;
			end
		end
		if (s_nxt.st == ST_LOAD && s_nxt.mode == MODE_MASTER_PARALLEL) begin
			s_nxt.addrOe = 1'b1;
			s_nxt.aclkOe = 1'b1;
		end
		if (s_nxt.st == ST_USER) begin
			s_nxt.rdyOut = userRdyOut;
			s_nxt.rdyOe = userRdyOe;
			s_nxt.aclk = userAclkOut;
			s_nxt.aclkOe = userAclkOe;
			s_nxt.sel1Out = userSel1Out;
			s_nxt.sel1Oe = userSel1Oe;
			s_nxt.sel0User = pinSync[SY_MODE0];
			s_nxt.sel2User = pinSync[SY_MODE2];
			s_nxt.tdo = userTdoOut;
			s_nxt.tdoOe = userTdoOe;
		end
		if (scanEnable) begin
			s_nxt.tdo = scanTdo;
			s_nxt.tdoOe = 1'b1;
		end
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			s_r <= '{st: ST_CLEAR, clrCnt: CLR_ZERO, mode: MODE_SLAVE_SERIAL, wsPrev: 1'b0,
				bufFull: 1'b0, byteBuf: BYTE_ZERO, initOe: 1'b1, erase: 1'b1, sel0User: 1'b0,
				sel2User: 1'b0, sel1Out: 1'b0, sel1Oe: 1'b0, topBit: 1'b1, dLow: LOW_BITS_HIGH,
				dOe: 1'b0, rdyOut: 1'b1, rdyOe: 1'b0, rdyPull: 1'b1, addr: ADDR_ZERO,
				addrOe: 1'b0, aclk: 1'b0, aclkOe: 1'b0, tdo: 1'b0, tdoOe: 1'b0};
		end else begin
			s_r <= s_nxt;
		end
	end

	assign initOe = s_r.initOe;
	assign eraseMem = s_r.erase;
	assign modeSampled = s_r.mode;
	assign modeSel0User = s_r.sel0User;
	assign modeSel2User = s_r.sel2User;
	assign modeSel1Out = s_r.sel1Out;
	assign modeSel1Oe = s_r.sel1Oe;
	assign top_data_bit = s_r.topBit;
	assign dataLowOut = s_r.dLow;
	assign dataOe = s_r.dOe;
	assign cfgByte = s_r.byteBuf;
	assign cfgByteValid = s_r.bufFull;
	assign readyBusyOut = s_r.rdyOut;
	assign readyBusyOe = s_r.rdyOe;
	assign readyBusyPullup = s_r.rdyPull;
	assign prom_address_out = s_r.addr;
	assign promAddrOe = s_r.addrOe;
	assign addrAdvClk = s_r.aclk;
	assign addrAdvClkOe = s_r.aclkOe;
	assign testDataOut = s_r.tdo;
	assign testDataOe = s_r.tdoOe;

	a_clear_erases: assert property (@(posedge clock) disable iff (!arst_n)
		!progN |=> eraseMem && initOe)
		else $error("erase not active during clear request");
	a_extra_clear: assert property (@(posedge clock) disable iff (!arst_n)
		(s_r.st == ST_FINISH && clrWrap && progN) |=> s_r.st == ST_EXTRA && s_r.clrCnt == CLR_ZERO)
		else $error("extra clear cycle not started from zero");
	a_extra_length: assert property (@(posedge clock) disable iff (!arst_n)
		(s_r.st == ST_EXTRA && !clrWrap && progN) |=> s_r.st == ST_EXTRA)
		else $error("extra clear cycle cut short");
	a_init_release: assert property (@(posedge clock) disable iff (!arst_n)
		(s_r.st == ST_EXTRA && clrWrap && progN) |=> !initOe && s_r.st == ST_WAIT)
		else $error("init not released after extra clear");
	a_mode_sample: assert property (@(posedge clock) disable iff (!arst_n)
		(s_r.st != ST_WAIT && $past(s_r.st) != ST_WAIT) |-> $stable(modeSampled))
		else $error("mode changed outside wait state");
	a_no_early_sample: assert property (@(posedge clock) disable iff (!arst_n)
		(s_r.st == ST_WAIT && !pinSync[SY_INIT]) |=> s_r.st != ST_LOAD)
		else $error("mode sampled while init low");
	a_rdy_pullup: assert property (@(posedge clock) disable iff (!arst_n)
		(s_r.st != ST_LOAD && s_r.st != ST_USER) |-> readyBusyPullup && !readyBusyOe)
		else $error("ready/busy driven before init high");
	a_rdy_status: assert property (@(posedge clock) disable iff (!arst_n)
		(s_r.st == ST_LOAD && periph && $past(s_r.st) == ST_LOAD) |-> readyBusyOut == !cfgByteValid)
		else $error("ready/busy does not track buffer");
	a_read_status: assert property (@(posedge clock) disable iff (!arst_n)
		dataOe |-> dataLowOut == LOW_BITS_HIGH && top_data_bit == readyBusyOut)
		else $error("read status bits wrong");
	a_addr_clock: assert property (@(posedge clock) disable iff (!arst_n)
		($changed(prom_address_out) && $past(s_r.st) == ST_LOAD)
		|-> $past(addrAdvClk) && !$past(addrAdvClk, 2))
		else $error("address changed without prior clock rise");
	a_tdo_scan: assert property (@(posedge clock) disable iff (!arst_n)
		scanEnable |=> testDataOe && testDataOut == $past(scanTdo))
		else $error("test output not carrying scan data");
endmodule : csmh_config_ctrl

// ---- bench/csmh_prom_model.sv ----
// Parallel configuration PROM model facing the address outputs
`timescale 1ns/1ps
module csmh_prom_model (
	input wire logic clock, // System clock
	input wire logic arst_n, // Async reset, active low
	input wire logic [17:0] addr, // PROM address from device
	input wire logic addrOe, // Address drive enable
	input wire logic aclk, // Address advance clock
	output logic [7:0] dataOut, // Byte on data pins
	output logic addrEarly // Address moved with no clock rise
);
	logic aclkSeen;
	logic [17:0] lastAddr;
	logic [7:0] lastData;

	// Released bus toggles so a stale byte never looks valid
	assign dataOut = addrOe ? (addr[7:0] ^ 8'hA5) : ~lastData;

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			aclkSeen <= 1'b0;
			lastAddr <= 18'h00000;
			lastData <= 8'h00;
			addrEarly <= 1'b0;
		end else begin
			lastData <= dataOut;
			if (aclk) begin
				aclkSeen <= 1'b1;
			end
			if (addr !== lastAddr) begin
				if (!aclkSeen && addrOe) begin
					addrEarly <= 1'b1;
				end
				aclkSeen <= aclk;
				lastAddr <= addr;
			end
		end
	end
endmodule : csmh_prom_model

// ---- bench/tb.sv ----
// Self-checking testbench for the configuration start and handshake block
`timescale 1ns/1ps
module tb;
	import csmh_pkg::*;
	logic clock, arst_n, programReqPin_n, initHold, initPinIn, initOe, eraseMem;
	logic cfg_mode_sel_0, cfg_mode_sel_1, cfg_mode_sel_2, modeSel0User, modeSel2User;
	logic [MODE_W-1:0] modeSampled;
	logic userSel1Out, userSel1Oe, modeSel1Out, modeSel1Oe;
	logic chip_select_low_active, chip_select_high_active, write_strobe_n, read_strobe_n;
	logic [DATA_W-1:0] dataPinIn, dataPinDrv, promData, cfgByte;
	logic hostDrive, top_data_bit, dataOe, cfgByteValid, loaderTake, cfgDone;
	logic [6:0] dataLowOut;
	logic readyBusyOut, readyBusyOe, readyBusyPullup, userRdyOut, userRdyOe, addrStepReq;
	logic [ADDR_W-1:0] prom_address_out;
	logic promAddrOe, addrAdvClk, addrAdvClkOe, userAclkOut, userAclkOe, addrEarly;
	logic scanEnable, scanTdo, userTdoOut, userTdoOe, testDataOut, testDataOe;
	int mismatches = 0;
	int cmp_count = 0;

	// Init wire: open drain with pull-up, held low by device or an outside party
	assign initPinIn = !(initOe || initHold);
	assign dataPinIn = hostDrive ? dataPinDrv : promData;

	csmh_config_ctrl csmh_config_ctrl_inst (.clock(clock), .arst_n(arst_n),
		.programReqPin_n(programReqPin_n), .initPinIn(initPinIn), .initOe(initOe),
		.eraseMem(eraseMem), .cfg_mode_sel_0(cfg_mode_sel_0), .cfg_mode_sel_1(cfg_mode_sel_1),
		.cfg_mode_sel_2(cfg_mode_sel_2), .modeSampled(modeSampled),
		.modeSel0User(modeSel0User), .modeSel2User(modeSel2User),
		.userSel1Out(userSel1Out), .userSel1Oe(userSel1Oe),
		.modeSel1Out(modeSel1Out), .modeSel1Oe(modeSel1Oe),
		.chip_select_low_active(chip_select_low_active),
		.chip_select_high_active(chip_select_high_active), .write_strobe_n(write_strobe_n),
		.read_strobe_n(read_strobe_n), .dataPinIn(dataPinIn), .top_data_bit(top_data_bit),
		.dataLowOut(dataLowOut), .dataOe(dataOe), .cfgByte(cfgByte),
		.cfgByteValid(cfgByteValid), .loaderTake(loaderTake), .cfgDone(cfgDone),
		.readyBusyOut(readyBusyOut), .readyBusyOe(readyBusyOe),
		.readyBusyPullup(readyBusyPullup), .userRdyOut(userRdyOut), .userRdyOe(userRdyOe),
		.addrStepReq(addrStepReq), .prom_address_out(prom_address_out),
		.promAddrOe(promAddrOe), .addrAdvClk(addrAdvClk), .addrAdvClkOe(addrAdvClkOe),
		.userAclkOut(userAclkOut), .userAclkOe(userAclkOe), .scanEnable(scanEnable),
		.scanTdo(scanTdo), .userTdoOut(userTdoOut), .userTdoOe(userTdoOe),
		.testDataOut(testDataOut), .testDataOe(testDataOe));

	csmh_prom_model csmh_prom_model_inst (.clock(clock), .arst_n(arst_n),
		.addr(prom_address_out), .addrOe(promAddrOe), .aclk(addrAdvClk),
		.dataOut(promData), .addrEarly(addrEarly));

	always #(CLK_PERIOD_NS / 2) clock = ~clock;

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			mismatches++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic step(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask : step

	task automatic start_config(input logic [MODE_W-1:0] m);
		int cnt;
		logic early;
		cnt = 0;
		early = 1'b0;
		programReqPin_n = 1'b0;
		{cfg_mode_sel_2, cfg_mode_sel_1, cfg_mode_sel_0} = m;
		initHold = 1'b1;
		step(5);
		check(eraseMem, 1);
		check(initOe, 1);
		check({readyBusyPullup, readyBusyOe}, 2'h2);
		programReqPin_n = 1'b1;
		while (initOe === 1'b1 && cnt < 120) begin
			if (eraseMem !== 1'b1) early = 1'b1;
			step(1);
			cnt++;
		end
		check(early, 0);
		check(cnt >= CLR_CYCLES + 1 && cnt <= 2 * CLR_CYCLES + 4, 1);
		step(3);
		check(eraseMem, 0);
		if (m != MODE_SLAVE_SERIAL) check(modeSampled !== m, 1);
		initHold = 1'b0;
		step(6);
		check(modeSampled, m);
	endtask : start_config

	task automatic host_write(input logic [7:0] b, input logic sel, input logic rd);
		chip_select_low_active = !sel;
		chip_select_high_active = sel;
		dataPinDrv = b;
		hostDrive = 1'b1;
		write_strobe_n = 1'b0;
		read_strobe_n = !rd;
		step(4);
		check(dataOe, 0);
		write_strobe_n = 1'b1;
		read_strobe_n = 1'b1;
		step(3);
		chip_select_low_active = 1'b1;
		chip_select_high_active = 1'b0;
		hostDrive = 1'b0;
		step(1);
	endtask : host_write

	task automatic host_read(input logic expRdy);
		chip_select_low_active = 1'b0;
		chip_select_high_active = 1'b1;
		read_strobe_n = 1'b0;
		step(4);
		check(dataOe, 1);
		check({top_data_bit, dataLowOut}, {expRdy, LOW_BITS_HIGH});
		read_strobe_n = 1'b1;
		step(4);
		check(dataOe, 0);
		chip_select_low_active = 1'b1;
		chip_select_high_active = 1'b0;
		step(1);
	endtask : host_read

	task automatic take_byte();
		loaderTake = 1'b1;
		step(1);
		loaderTake = 1'b0;
		step(2);
	endtask : take_byte

	task automatic parallel_load();
		start_config(MODE_MASTER_PARALLEL);
		check({promAddrOe, prom_address_out}, {1'b1, ADDR_ZERO});
		for (int i = 1; i <= 3; i++) begin
			addrStepReq = 1'b1;
			step(1);
			addrStepReq = 1'b0;
			check({addrAdvClk, prom_address_out}, {1'b1, ADDR_W'(i - 1)});
			step(1);
			check({addrAdvClk, prom_address_out}, {1'b0, ADDR_W'(i)});
		end
		check(addrEarly, 0);
	endtask : parallel_load

	task automatic periph_load();
		start_config(MODE_PERIPH_ASYNC);
		check({readyBusyOe, readyBusyOut}, 2'h3);
		host_write(8'h96, 1'b0, 1'b0);
		check(cfgByteValid, 0);
		host_write(8'h3C, 1'b1, 1'b0);
		check({cfgByteValid, cfgByte}, 9'h13C);
		check(readyBusyOut, 0);
		host_read(1'b0);
		host_write(8'hC3, 1'b1, 1'b0);
		check(cfgByte, 8'h3C);
		take_byte();
		check({cfgByteValid, readyBusyOut}, 2'h1);
		host_read(1'b1);
		host_write(8'h5A, 1'b1, 1'b1);
		check({cfgByteValid, cfgByte}, 9'h15A);
		take_byte();
	endtask : periph_load

	task automatic sync_periph();
		start_config(MODE_PERIPH_SYNC);
		check({readyBusyOe, readyBusyOut, promAddrOe}, 3'h6);
		host_write(8'h81, 1'b1, 1'b1);
		check(cfgByteValid, 0);
		check(dataOe, 0);
	endtask : sync_periph

	task automatic user_pins();
		start_config(MODE_SLAVE_SERIAL);
		cfgDone = 1'b1;
		step(1);
		cfgDone = 1'b0;
		{userRdyOut, userRdyOe, userAclkOut, userAclkOe, userSel1Out, userSel1Oe} = 6'h1F;
		cfg_mode_sel_0 = 1'b0;
		scanEnable = 1'b1;
		scanTdo = 1'b1;
		step(4);
		check({readyBusyOe, readyBusyOut}, 2'h2);
		check({addrAdvClkOe, addrAdvClk}, 2'h3);
		check({modeSel1Oe, modeSel1Out, modeSel0User, modeSel2User}, 4'hD);
		check({testDataOe, testDataOut}, 2'h3);
		scanEnable = 1'b0;
		{userTdoOut, userTdoOe} = 2'h1;
		step(2);
		check({testDataOe, testDataOut}, 2'h2);
	endtask : user_pins

	task automatic results();
		if (mismatches == 0 && cmp_count > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : results

	initial begin
		clock = 1'b0;
		arst_n = 1'b0;
		{programReqPin_n, initHold, cfg_mode_sel_0, cfg_mode_sel_1, cfg_mode_sel_2} = 5'h1F;
		{userSel1Out, userSel1Oe, userRdyOut, userRdyOe, userAclkOut, userAclkOe} = 6'h00;
		{chip_select_low_active, chip_select_high_active, write_strobe_n, read_strobe_n} = 4'hB;
		{hostDrive, loaderTake, cfgDone, addrStepReq} = 4'h0;
		{scanEnable, scanTdo, userTdoOut, userTdoOe} = 4'h0;
		dataPinDrv = BYTE_ZERO;
		repeat (5) @(posedge clock);
		#1;
		arst_n = 1'b1;
		step(3);
		parallel_load();
		periph_load();
		sync_periph();
		user_pins();
		results();
	end

	initial begin
		#(CLK_PERIOD_NS * 4000);
		mismatches++;
		results();
	end
endmodule : tb
